// ===== verilog/tgc_defines.svh
`ifndef TGC_DEFINES_SVH
`define TGC_DEFINES_SVH
// How it works
// - three address bits, eight data bits, MSB first
// - host writes only while transmit enable low
// - new setting acts at twelfth rising edge
// - host waits 100 us after power-up
// - chip select active low opens transaction
// - read starts with chip select, direction 1
// - device samples data at serial clock rise
// - host sends read address, then releases line
// - device drives requested byte, MSB first
// - device releases data line at select rise
// - write: direction 0, address, data, MSB first
// - register updates at twelfth rising edge
// - bits 7:6 power code, 0 min 3 max
// - bits 5:0 gain code, 0 min 3f max
// - every gain code allowed under every power code
// - transmit enable low powers down output amplifiers
// - gain steps 1 dB over 60 dB range

`define TGC_MCLK_MHZ       125
`define TGC_SCLK_HIGH_NS   50
`define TGC_SCLK_HALF_CYC  ((`TGC_SCLK_HIGH_NS * `TGC_MCLK_MHZ + 999) / 1000)
`define TGC_POWERUP_US     100
`define TGC_POWERUP_CYC    (`TGC_POWERUP_US * `TGC_MCLK_MHZ)
`define TGC_HDR_BITS       4'h4
`define TGC_FRAME_BITS     4'hc
`define TGC_DIR_READ       1'b1
`define TGC_REG_GAIN_ADDR  3'h0
`define TGC_REG_RESET      8'h00
`define TGC_PWR_MSB        7
`define TGC_PWR_LSB        6
`define TGC_GAIN_MSB       5
`define TGC_GAIN_LSB       0
`define TGC_GAIN_DB_MAX    6'h3c
`define TGC_H_CTRL         2'h0
`define TGC_H_WDATA        2'h1
`define TGC_H_STATUS       2'h2
`define TGC_H_RDATA        2'h3
`define TGC_CTRL_START     0
`define TGC_CTRL_READ      1
`define TGC_CTRL_TRANSMIT_ENABLE_IN      2
`define TGC_CTRL_ADDR_LSB  4
`define TGC_ST_BUSY        0
`define TGC_ST_DONE        1
`define TGC_ST_REFUSED     2
`define TGC_ST_POWERED     3
`endif

// ===== verilog/tgc_pkg.sv
package tgc_pkg;
	typedef enum logic [2:0] {DEV_IDLE, DEV_HDR, DEV_WR, DEV_RD, DEV_END} tgc_dev_phase_type;
	typedef enum logic [1:0] {HST_IDLE, HST_BITS, HST_HOLD} tgc_host_phase_type;

	typedef struct packed {
		logic [2:0]        sclk_sync;
		logic [2:0]        csn_sync;
		logic [1:0]        sda_sync;
		logic [1:0]        transmit_enable_in_sync;
		tgc_dev_phase_type phase;
		logic [3:0]        bit_cnt;
		logic [10:0]       shift_in;
		logic [2:0]        addr;
		logic [7:0]        shift_out;
		logic              sda_oe;
		logic              sda_out;
		logic [7:0]        gain_power_control;
		logic [5:0]        gain_db;
		logic              amp_enable;
		logic              write_in_tx;
	} tgc_dev_state_type;

	typedef struct packed {
		logic [1:0]         sda_sync;
		tgc_host_phase_type phase;
		logic               sclk;
		logic               chip_select_n;
		logic               sda_out;
		logic               sda_oe;
		logic [3:0]         div_cnt;
		logic [3:0]         bit_cnt;
		logic [11:0]        frame;
		logic [7:0]         rd_shift;
		logic [13:0]        pwr_cnt;
		logic               powered;
		logic               busy;
		logic               done;
		logic               refused;
		logic               ctrl_read;
		logic [2:0]         ctrl_addr;
		logic               ctrl_transmit_enable_in;
		logic [7:0]         wdata;
		logic [7:0]         rdata;
		logic [7:0]         port_rdata;
	} tgc_host_state_type;
endpackage : tgc_pkg

// ===== verilog/tgc_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tgc_if;
	logic sclk;
	logic chip_select_n;
	logic transmit_enable_in;
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic sda;

	// pull-up keeps the idle line high
	assign sda = sda_host_oe ? sda_host_o : (sda_dev_oe ? sda_dev_o : 1'b1);

	modport host (
		output sclk,
		output chip_select_n,
		output transmit_enable_in,
		output sda_host_o,
		output sda_host_oe,
		input  sda
	);
	modport dev (
		input  sclk,
		input  chip_select_n,
		input  transmit_enable_in,
		input  sda,
		output sda_dev_o,
		output sda_dev_oe
	);
endinterface : tgc_if
`default_nettype wire

// ===== verilog/tgc_dev.sv
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "tgc_defines.svh"
module tgc_dev (
	input  wire logic  i_mclk,
	input  wire logic  i_rst_n,
	tgc_if.dev         link,
	output logic [1:0] o_power_setting,
	output logic [5:0] o_gain_setting,
	output logic [5:0] o_gain_db,
	output logic       o_amp_enable,
	output logic       o_write_in_tx
);
	tgc_pkg::tgc_dev_state_type st_ff;
	tgc_pkg::tgc_dev_state_type nxt_st;

	logic sclk_rise;
	logic sclk_fall;
	logic cs_low;
	logic cs_open;
	logic sda_bit;
	logic transmit_enable_in_lvl;

	function automatic logic addr_hit(input logic [2:0] a);
		addr_hit = (a == `TGC_REG_GAIN_ADDR);
	endfunction : addr_hit

	function automatic logic [5:0] gain_to_db(input logic [5:0] g);
		// codes past the range saturate at the top step
		gain_to_db = (g > `TGC_GAIN_DB_MAX) ? `TGC_GAIN_DB_MAX : g;
	endfunction : gain_to_db

	// edge detection reads only the second and third stages
	assign sclk_rise = st_ff.sclk_sync[1] & ~st_ff.sclk_sync[2];
	assign sclk_fall = ~st_ff.sclk_sync[1] & st_ff.sclk_sync[2];
	assign cs_low    = ~st_ff.csn_sync[1];
	assign cs_open   = ~st_ff.csn_sync[1] & st_ff.csn_sync[2];
	assign sda_bit   = st_ff.sda_sync[1];
	assign transmit_enable_in_lvl  = st_ff.transmit_enable_in_sync[1];

	always_comb begin
		nxt_st = st_ff;
		nxt_st.sclk_sync = {st_ff.sclk_sync[1:0], link.sclk};
		nxt_st.csn_sync  = {st_ff.csn_sync[1:0], link.chip_select_n};
		nxt_st.sda_sync  = {st_ff.sda_sync[0], link.sda};
		nxt_st.transmit_enable_in_sync = {st_ff.transmit_enable_in_sync[0], link.transmit_enable_in};
		nxt_st.write_in_tx = 1'b0;
		nxt_st.amp_enable = transmit_enable_in_lvl;

		if (!cs_low) begin
			// select high ends or aborts any frame; short frames change nothing
			nxt_st.phase   = tgc_pkg::DEV_IDLE;
			nxt_st.bit_cnt = 4'h0;
			nxt_st.sda_oe  = 1'b0;
			nxt_st.sda_out = 1'b0;
		end else begin
			case (st_ff.phase)
				tgc_pkg::DEV_IDLE: begin
					if (cs_open) begin
						nxt_st.phase   = tgc_pkg::DEV_HDR;
						nxt_st.bit_cnt = 4'h0;
					end
				end
				tgc_pkg::DEV_HDR: begin
					if (sclk_rise) begin
						nxt_st.shift_in = {st_ff.shift_in[9:0], sda_bit};
						nxt_st.bit_cnt  = st_ff.bit_cnt + 4'h1;
						if (st_ff.bit_cnt == `TGC_HDR_BITS - 4'h1) begin
							nxt_st.addr = {st_ff.shift_in[1:0], sda_bit};
							if (st_ff.shift_in[2] == `TGC_DIR_READ) begin
								nxt_st.phase = tgc_pkg::DEV_RD;
								// unmapped addresses read as zero
								nxt_st.shift_out = addr_hit({st_ff.shift_in[1:0], sda_bit}) ?
									st_ff.gain_power_control : 8'h00;
							end else begin
								nxt_st.phase = tgc_pkg::DEV_WR;
							end
						end
					end
				end
				tgc_pkg::DEV_WR: begin
					if (sclk_rise) begin
						nxt_st.shift_in = {st_ff.shift_in[9:0], sda_bit};
						nxt_st.bit_cnt  = st_ff.bit_cnt + 4'h1;
						if (st_ff.bit_cnt == `TGC_FRAME_BITS - 4'h1) begin
							nxt_st.phase = tgc_pkg::DEV_END;
							if (addr_hit(st_ff.addr)) begin
								// any power and gain pairing is taken as is
								nxt_st.gain_power_control = {st_ff.shift_in[6:0], sda_bit};
								nxt_st.gain_db = gain_to_db(st_ff.shift_in[4:0] == 5'h00 ?
									{5'h00, sda_bit} : {st_ff.shift_in[4:0], sda_bit});
								// flags a host that wrote during a burst
								nxt_st.write_in_tx = transmit_enable_in_lvl;
							end
						end
					end
				end
				tgc_pkg::DEV_RD: begin
					// drive on the falling edge so the host samples a settled bit
					if (sclk_fall) begin
						nxt_st.sda_oe    = 1'b1;
						nxt_st.sda_out   = st_ff.shift_out[7];
						nxt_st.shift_out = {st_ff.shift_out[6:0], 1'b0};
					end
					if (sclk_rise) begin
						nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
						if (st_ff.bit_cnt == `TGC_FRAME_BITS - 4'h1) begin
							nxt_st.phase = tgc_pkg::DEV_END;
						end
					end
				end
				tgc_pkg::DEV_END: begin
					// last bit held until select rises
					nxt_st.phase = tgc_pkg::DEV_END;
				end
				default: begin
					nxt_st.phase  = tgc_pkg::DEV_IDLE;
					nxt_st.sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			st_ff <= '0;
			st_ff.phase <= tgc_pkg::DEV_IDLE;
			st_ff.sclk_sync <= 3'h0;
			st_ff.csn_sync <= 3'h7;
			st_ff.gain_power_control <= `TGC_REG_RESET;
			st_ff.gain_db <= 6'h00;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// operating point moves only with the stored register
	assign o_power_setting = st_ff.gain_power_control[`TGC_PWR_MSB:`TGC_PWR_LSB];
	assign o_gain_setting  = st_ff.gain_power_control[`TGC_GAIN_MSB:`TGC_GAIN_LSB];
	assign o_gain_db       = st_ff.gain_db;
	assign o_amp_enable    = st_ff.amp_enable;
	assign o_write_in_tx   = st_ff.write_in_tx;
	assign link.sda_dev_o  = st_ff.sda_out;
	assign link.sda_dev_oe = st_ff.sda_oe;
endmodule : tgc_dev
`default_nettype wire

// ===== verilog/tgc_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "tgc_defines.svh"
module tgc_host #(
	parameter int POWERUP_CYC = `TGC_POWERUP_CYC
) (
	input  wire logic       i_mclk,
	input  wire logic       i_rst_n,
	tgc_if.host             link,
	input  wire logic [1:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic [7:0]      o_rdata
);
	localparam logic [3:0] HALF_LAST = 4'(`TGC_SCLK_HALF_CYC - 1);
	localparam logic [13:0] PWR_LAST = 14'(POWERUP_CYC - 1);

	tgc_pkg::tgc_host_state_type st_ff;
	tgc_pkg::tgc_host_state_type nxt_st;

	logic       start_req;
	logic [7:0] status;

	assign start_req = i_wr & (i_addr == `TGC_H_CTRL) & i_wdata[`TGC_CTRL_START];
	assign status = {4'h0, st_ff.powered, st_ff.refused, st_ff.done, st_ff.busy};

	always_comb begin
		nxt_st = st_ff;
		nxt_st.sda_sync = {st_ff.sda_sync[0], link.sda};
		nxt_st.port_rdata = 8'h00;
		if (!st_ff.powered) begin
			nxt_st.pwr_cnt = st_ff.pwr_cnt + 14'h1;
			nxt_st.powered = (st_ff.pwr_cnt == PWR_LAST);
		end
		if (i_rd) begin
			case (i_addr)
				`TGC_H_CTRL:   nxt_st.port_rdata = {1'b0, st_ff.ctrl_addr, 1'b0,
					st_ff.ctrl_transmit_enable_in, st_ff.ctrl_read, 1'b0};
				`TGC_H_WDATA:  nxt_st.port_rdata = st_ff.wdata;
				`TGC_H_STATUS: nxt_st.port_rdata = status;
				default:       nxt_st.port_rdata = st_ff.rdata;
			endcase
			if (i_addr == `TGC_H_STATUS) begin
				nxt_st.done    = 1'b0;
				nxt_st.refused = 1'b0;
			end
		end
		if (i_wr && i_addr == `TGC_H_CTRL && !st_ff.busy) begin
			nxt_st.ctrl_read = i_wdata[`TGC_CTRL_READ];
			nxt_st.ctrl_transmit_enable_in = i_wdata[`TGC_CTRL_TRANSMIT_ENABLE_IN];
			nxt_st.ctrl_addr = i_wdata[`TGC_CTRL_ADDR_LSB +: 3];
		end
		if (i_wr && i_addr == `TGC_H_WDATA && !st_ff.busy) begin
			nxt_st.wdata = i_wdata;
		end
		if (start_req) begin
			// a write during a burst or before settling is dropped, not delayed
			if (st_ff.busy || !st_ff.powered ||
				(!i_wdata[`TGC_CTRL_READ] && i_wdata[`TGC_CTRL_TRANSMIT_ENABLE_IN])) begin
				nxt_st.refused = 1'b1;
			end else begin
				nxt_st.frame = {i_wdata[`TGC_CTRL_READ], i_wdata[`TGC_CTRL_ADDR_LSB +: 3],
					st_ff.wdata};
				nxt_st.chip_select_n = 1'b0;
				nxt_st.sda_oe  = 1'b1;
				nxt_st.sda_out = i_wdata[`TGC_CTRL_READ];
				nxt_st.sclk    = 1'b0;
				nxt_st.div_cnt = 4'h0;
				nxt_st.bit_cnt = 4'h0;
				nxt_st.busy    = 1'b1;
				nxt_st.phase   = tgc_pkg::HST_BITS;
			end
		end
		case (st_ff.phase)
			tgc_pkg::HST_IDLE: begin
				nxt_st.sclk = 1'b0;
			end
			tgc_pkg::HST_BITS: begin
				nxt_st.div_cnt = st_ff.div_cnt + 4'h1;
				if (st_ff.div_cnt == HALF_LAST) begin
					nxt_st.div_cnt = 4'h0;
					nxt_st.sclk = ~st_ff.sclk;
					if (!st_ff.sclk) begin
						nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
						if (st_ff.ctrl_read && st_ff.bit_cnt >= `TGC_HDR_BITS) begin
							nxt_st.rd_shift = {st_ff.rd_shift[6:0], st_ff.sda_sync[1]};
						end
					end else if (st_ff.bit_cnt == `TGC_FRAME_BITS) begin
						nxt_st.phase = tgc_pkg::HST_HOLD;
					end else begin
						nxt_st.frame   = {st_ff.frame[10:0], 1'b0};
						nxt_st.sda_out = st_ff.frame[10];
						if (st_ff.ctrl_read && st_ff.bit_cnt >= `TGC_HDR_BITS) begin
							nxt_st.sda_oe = 1'b0;
						end
					end
				end
			end
			tgc_pkg::HST_HOLD: begin
				nxt_st.div_cnt = st_ff.div_cnt + 4'h1;
				if (st_ff.div_cnt == HALF_LAST) begin
					nxt_st.chip_select_n = 1'b1;
					nxt_st.sda_oe = 1'b0;
					nxt_st.busy   = 1'b0;
					nxt_st.done   = 1'b1;
					nxt_st.rdata  = st_ff.ctrl_read ? st_ff.rd_shift : st_ff.rdata;
					nxt_st.phase  = tgc_pkg::HST_IDLE;
				end
			end
			default: begin
				nxt_st.phase = tgc_pkg::HST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			st_ff <= '0;
			st_ff.phase <= tgc_pkg::HST_IDLE;
			st_ff.chip_select_n <= 1'b1;
			st_ff.sda_sync <= 2'h3;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_rdata = st_ff.port_rdata;
	assign link.sclk = st_ff.sclk;
	assign link.chip_select_n = st_ff.chip_select_n;
	assign link.transmit_enable_in = st_ff.ctrl_transmit_enable_in;
	assign link.sda_host_o = st_ff.sda_out;
	assign link.sda_host_oe = st_ff.sda_oe;
endmodule : tgc_host
`default_nettype wire

// ===== bench/tgc_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module tgc_monitor (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic sclk,
	input wire logic chip_select_n,
	input wire logic transmit_enable_in,
	input wire logic sda_host_o,
	input wire logic sda_host_oe,
	input wire logic sda_dev_oe
);
	logic [3:0] rises_ff;
	logic       sclk_ff;

	// counts rises seen in the current frame, cleared while deselected
	always_ff @(posedge i_mclk) begin
		sclk_ff <= i_rst_n & sclk;
		if (!i_rst_n || chip_select_n) rises_ff <= 4'h0;
		else if (sclk && !sclk_ff) rises_ff <= rises_ff + 4'h1;
	end

	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	a_frame_twelve_rises: assert property ($rose(chip_select_n) |-> rises_ff == 4'hc)
		else $error("frame closed after a wrong count of clock rises");
	a_select_lead: assert property ($fell(chip_select_n) |-> !sclk [*7])
		else $error("serial clock rose too soon after select");
	a_idle_clock_low: assert property (chip_select_n |-> !sclk)
		else $error("serial clock high outside a frame");
	a_sclk_high_time: assert property ($rose(sclk) |-> sclk [*7] ##1 !sclk)
		else $error("serial clock high time wrong");
	a_data_hold_high: assert property (sclk |-> $stable(sda_host_o) && $stable(sda_host_oe))
		else $error("host data moved while clock high");
	a_write_tx_off: assert property ($fell(chip_select_n) && !sda_host_o |-> !transmit_enable_in)
		else $error("write frame started with transmit enabled");
	a_header_by_host: assert property (!chip_select_n && rises_ff < 4'h4 |-> sda_host_oe && !sda_dev_oe)
		else $error("header bits not driven by host");
	a_no_fight: assert property (!(sda_host_oe && sda_dev_oe))
		else $error("both ends drive the data line");
	a_read_turn: assert property ($fell(sda_host_oe) && !chip_select_n |-> ##[1:6] sda_dev_oe)
		else $error("device did not take over the data line");
	a_dev_release: assert property (chip_select_n [*6] |-> !sda_dev_oe)
		else $error("device still drives after deselect");

	c_write_frame: cover property ($fell(chip_select_n) && !sda_host_o);
	c_read_frame: cover property ($fell(chip_select_n) && sda_host_o);
	c_turnaround: cover property ($fell(sda_host_oe) && !chip_select_n);
endmodule : tgc_monitor
`default_nettype wire

// ===== bench/tb_three_wire_gain_ctrl_port.sv
`timescale 1ns/10ps
`default_nettype none
module tb_three_wire_gain_ctrl_port;
	logic        i_mclk;
	logic        i_rst_n;
	logic [1:0]  i_addr;
	logic [7:0]  i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [7:0]  o_rdata;
	logic [1:0]  pwr;
	logic [5:0]  gain;
	logic [5:0]  gdb;
	logic        amp;
	logic        wtx;
	logic        wtx_seen;
	logic [11:0] cap;
	logic [7:0]  s;
	int          n_mismatch;
	int          checked;

	tgc_if link ();
	// short power-up wait keeps the run brief
	tgc_host #(.POWERUP_CYC(20)) i_tgc_host (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .link(link),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
	tgc_dev i_tgc_dev (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .link(link), .o_power_setting(pwr),
		.o_gain_setting(gain), .o_gain_db(gdb), .o_amp_enable(amp), .o_write_in_tx(wtx));
	tgc_monitor i_tgc_monitor (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .sclk(link.sclk),
		.chip_select_n(link.chip_select_n), .transmit_enable_in(link.transmit_enable_in),
		.sda_host_o(link.sda_host_o), .sda_host_oe(link.sda_host_oe),
		.sda_dev_oe(link.sda_dev_oe));

	// wire view of each frame, whichever end drives
	always @(posedge link.sclk) if (!link.chip_select_n) cap <= {cap[10:0], link.sda};

	// the flag is a one-cycle pulse, so keep it until the end
	always @(posedge i_mclk) begin
		if (!i_rst_n) wtx_seen <= 1'b0;
		else if (wtx) wtx_seen <= 1'b1;
	end

	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask : rd

	// d is the byte sent, or the byte a read must return
	task automatic frame(input logic r, input logic [2:0] a, input logic [7:0] d);
		logic [7:0] old;
		old = {pwr, gain};
		s = 8'h00;
		wr(2'h1, d);
		wr(2'h0, {1'b0, a, 2'h0, r, 1'b1});
		rd(2'h2, s);
		chk(16'({s[0], link.chip_select_n}), 16'h2);
		repeat (150) @(posedge i_mclk);
		chk(16'({pwr, gain}), 16'(old));
		for (int k = 0; k < 200 && s[1] !== 1'b1; k++) rd(2'h2, s);
		chk(16'(s[1]), 16'h1);
		chk(16'(cap), 16'({r, a, d}));
	endtask : frame

	task automatic s_write;
		logic [7:0] v[5] = '{8'hff, 8'h3c, 8'hc0, 8'h7d, 8'h81};
		foreach (v[i]) begin
			frame(1'b0, 3'h0, v[i]);
			chk(16'({pwr, gain, gdb}), 16'({v[i], (v[i][5:0] > 6'h3c) ? 6'h3c : v[i][5:0]}));
			frame(1'b1, 3'h0, v[i]);
			rd(2'h3, s);
			chk(16'(s), 16'(v[i]));
		end
	endtask : s_write

	task automatic s_other;
		frame(1'b0, 3'h2, 8'h55);
		chk(16'({pwr, gain}), 16'h81);
		frame(1'b1, 3'h5, 8'h00);
		rd(2'h3, s);
		chk(16'(s), 16'h0);
	endtask : s_other

	task automatic s_transmit_enable_in;
		wr(2'h0, 8'h04);
		rd(2'h0, s);
		chk(16'(s), 16'h04);
		repeat (6) @(posedge i_mclk);
		chk(16'(amp), 16'h1);
		wr(2'h1, 8'h12);
		rd(2'h1, s);
		chk(16'(s), 16'h12);
		wr(2'h0, 8'h05);
		rd(2'h2, s);
		chk(16'({s[2], link.chip_select_n}), 16'h3);
		wr(2'h0, 8'h00);
		repeat (6) @(posedge i_mclk);
		chk(16'({amp, pwr, gain}), 16'h081);
		chk(16'(wtx_seen), 16'h0);
	endtask : s_transmit_enable_in

	task automatic s_powerup;
		chk(16'({pwr, gain, gdb}), 16'h0);
		wr(2'h0, 8'h01);
		rd(2'h2, s);
		chk(16'(s[3:2]), 16'h1);
		repeat (30) @(posedge i_mclk);
		rd(2'h2, s);
		chk(16'(s[3:2]), 16'h2);
	endtask : s_powerup

	task automatic wrap_up;
		if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	initial begin
		i_rst_n = 1'b0;
		i_addr = 2'h0;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		n_mismatch = 0;
		checked = 0;
		repeat (8) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		s_powerup();
		s_write();
		s_other();
		s_transmit_enable_in();
		wrap_up();
	end

	// whole run needs about 2300 cycles
	initial begin
		repeat (20000) @(posedge i_mclk);
		n_mismatch++;
		wrap_up();
	end
endmodule : tb_three_wire_gain_ctrl_port
`default_nettype wire
